// File: hw/wgrc_pkg.sv
// Operation
// - each sensor override value is six bits; the master writes only 0 to 63
// - an override value is taken only while that sensor's override enable is set
// - with automatic brightness on, a taken value seeds the automatic loop start point
// - command bits 0 to 7 are reserved, ignored, and written as zero
// - bit 8 hands control to the remote master and disables local control
// - bit 9 selects manual mode at zero and automatic mode at one
// - in manual mode bit 10 is a level jog left; never altered at travel end
// - in manual mode bit 11 is a level jog right; never altered at travel end
// - in automatic mode a rising bit 10 lowers the guide point one 0.254 mm step
// - in automatic mode a rising bit 11 raises the guide point one 0.254 mm step
// - automatic steps are momentary; only a zero to one transition steps
// - guide point steps saturate at a limit set by sensor resolution and width
// - brightness word bit 14 enables sensor one override, bit 6 sensor two
// - no brightness setting takes effect unless brightness word bit 15 is set
package wgrc_pkg;
	localparam int WGRC_CMD_W = 16;
	localparam int WGRC_BRT_W = 6;
	localparam int WGRC_GP_W = 16;
	localparam logic [15:0] WGRC_CMD_RST = 16'h0000;
	localparam int WGRC_BIT_REMOTE = 8;
	localparam int WGRC_BIT_AUTO = 9;
	localparam int WGRC_BIT_LEFT = 10;
	localparam int WGRC_BIT_RIGHT = 11;
	localparam int WGRC_BIT_S1_OVR = 14;
	localparam int WGRC_BIT_S2_OVR = 6;
	localparam int WGRC_BIT_LIGHT = 15;
	localparam logic [5:0] WGRC_BRT_MAX = 6'h3f;
	localparam logic [15:0] WGRC_GP_RST = 16'h0000;
	// one step is 0.254 mm; guide point counts in 0.0635 mm units
	localparam logic [15:0] WGRC_GP_STEP = 16'h0004;
	typedef struct packed {
		logic remote;
		logic auto_mode;
		logic jog_left;
		logic jog_right;
	} wgrc_ctrl_t;
	typedef struct packed {
		logic load;
		logic seed;
		logic [5:0] value;
	} wgrc_brt_t;
endpackage

// File: hw/wgrc_brt_ovr.sv
`timescale 1ns/1ps
module wgrc_brt_ovr
	import wgrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic light_enable,
	input wire logic ovr_enable,
	input wire logic auto_on,
	input wire logic wr,
	input wire logic [5:0] wr_value,
	output wgrc_brt_t brt
);
	wgrc_brt_t brt_ff;
	logic take;
	assign take = wr && light_enable && ovr_enable;
	always_ff @(posedge clk) begin
		if (rst) begin
			brt_ff <= '0;
		end else begin
			brt_ff.load <= take && !auto_on;
			brt_ff.seed <= take && auto_on;
			if (take) begin
				// values above 63 cannot be held; the field is six bits
				brt_ff.value <= wr_value;
			end
		end
	end
	assign brt = brt_ff;
	a_ovr_gated: assert property (@(posedge clk) disable iff (rst)
		(wr && !(light_enable && ovr_enable)) |=> !brt.load && !brt.seed)
		else $error("override taken while disabled");
	a_seed_auto: assert property (@(posedge clk) disable iff (rst)
		(take && auto_on) |=> brt.seed && !brt.load && brt.value == $past(wr_value))
		else $error("auto seed missing");
endmodule

// File: hw/wgrc_top.sv
`timescale 1ns/1ps
module wgrc_top
	import wgrc_pkg::*;
#(
	parameter logic [15:0] GP_MIN = 16'h8000,
	parameter logic [15:0] GP_MAX = 16'h7fff
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_data,
	input wire logic brt_cmd_wr,
	input wire logic [15:0] brt_cmd_data,
	input wire logic auto_brt_s1,
	input wire logic auto_brt_s2,
	input wire logic s1_val_wr,
	input wire logic [5:0] s1_val_data,
	input wire logic s2_val_wr,
	input wire logic [5:0] s2_val_data,
	output wgrc_ctrl_t ctrl,
	output logic local_enable,
	output logic signed [15:0] guide_point,
	output wgrc_brt_t s1_brt,
	output wgrc_brt_t s2_brt
);
	logic [15:0] cmd_ff;
	logic [15:0] brt_cmd_ff;
	logic signed [15:0] gp_ff;
	logic signed [15:0] nxt_gp;
	logic step_dn;
	logic step_up;
	logic signed [16:0] gp_sum;
	// reserved bits 0..7 are stored but steer nothing
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_ff <= WGRC_CMD_RST;
		end else if (cmd_wr) begin
			cmd_ff <= cmd_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			brt_cmd_ff <= WGRC_CMD_RST;
		end else if (brt_cmd_wr) begin
			brt_cmd_ff <= brt_cmd_data;
		end
	end
	// rising edge against the stored previous word, so a held bit steps once
	assign step_dn = cmd_wr && cmd_data[WGRC_BIT_AUTO] && cmd_data[WGRC_BIT_LEFT]
		&& !cmd_ff[WGRC_BIT_LEFT];
	assign step_up = cmd_wr && cmd_data[WGRC_BIT_AUTO] && cmd_data[WGRC_BIT_RIGHT]
		&& !cmd_ff[WGRC_BIT_RIGHT];
	always_comb begin
		gp_sum = {gp_ff[15], gp_ff};
		if (step_up && !step_dn) begin
			gp_sum = {gp_ff[15], gp_ff} + {1'b0, WGRC_GP_STEP};
		end else if (step_dn && !step_up) begin
			gp_sum = {gp_ff[15], gp_ff} - {1'b0, WGRC_GP_STEP};
		end
		if (gp_sum > $signed({GP_MAX[15], GP_MAX})) begin
			nxt_gp = $signed(GP_MAX);
		end else if (gp_sum < $signed({GP_MIN[15], GP_MIN})) begin
			nxt_gp = $signed(GP_MIN);
		end else begin
			nxt_gp = gp_sum[15:0];
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			gp_ff <= WGRC_GP_RST;
		end else begin
			gp_ff <= nxt_gp;
		end
	end
	assign guide_point = gp_ff;
	// jog bits are levels from the stored word, forced low in automatic mode; travel end never clears them
	always_comb begin
		ctrl.remote = cmd_ff[WGRC_BIT_REMOTE];
		ctrl.auto_mode = cmd_ff[WGRC_BIT_AUTO];
		ctrl.jog_left = !cmd_ff[WGRC_BIT_AUTO] && cmd_ff[WGRC_BIT_LEFT];
		ctrl.jog_right = !cmd_ff[WGRC_BIT_AUTO] && cmd_ff[WGRC_BIT_RIGHT];
	end
	assign local_enable = !cmd_ff[WGRC_BIT_REMOTE];
	wgrc_brt_ovr u_s1 (
		.clk(clk),
		.rst(rst),
		.light_enable(brt_cmd_ff[WGRC_BIT_LIGHT]),
		.ovr_enable(brt_cmd_ff[WGRC_BIT_S1_OVR]),
		.auto_on(auto_brt_s1),
		.wr(s1_val_wr),
		.wr_value(s1_val_data),
		.brt(s1_brt)
	);
	wgrc_brt_ovr u_s2 (
		.clk(clk),
		.rst(rst),
		.light_enable(brt_cmd_ff[WGRC_BIT_LIGHT]),
		.ovr_enable(brt_cmd_ff[WGRC_BIT_S2_OVR]),
		.auto_on(auto_brt_s2),
		.wr(s2_val_wr),
		.wr_value(s2_val_data),
		.brt(s2_brt)
	);
	// reset state; these run without disable so the reset itself is watched
	a_rst_ctrl: assert property (@(posedge clk)
		rst
		|=> ctrl == '0)
		else $error("control not cleared by reset");

	a_rst_local: assert property (@(posedge clk)
		rst
		|=> local_enable)
		else $error("local control not restored by reset");

	a_rst_gp: assert property (@(posedge clk)
		rst
		|=> guide_point == $signed(WGRC_GP_RST))
		else $error("guide point not cleared by reset");

	a_rst_s1_brt: assert property (@(posedge clk)
		rst
		|=> s1_brt == '0)
		else $error("sensor one brightness not cleared by reset");

	a_rst_s2_brt: assert property (@(posedge clk)
		rst
		|=> s2_brt == '0)
		else $error("sensor two brightness not cleared by reset");

	// command word levels
	a_remote_local: assert property (@(posedge clk) disable iff (rst)
		cmd_wr
		|=> local_enable == !$past(cmd_data[WGRC_BIT_REMOTE]) && ctrl.remote == $past(cmd_data[WGRC_BIT_REMOTE]))
		else $error("remote or local control wrong");

	a_local_inverse: assert property (@(posedge clk) disable iff (rst)
		local_enable == !ctrl.remote)
		else $error("local and remote control overlap");

	a_idle_ctrl: assert property (@(posedge clk) disable iff (rst)
		!cmd_wr
		|=> $stable(ctrl) && $stable(local_enable))
		else $error("control changed without a write");

	a_mode_sel: assert property (@(posedge clk) disable iff (rst)
		cmd_wr
		|=> ctrl.auto_mode == $past(cmd_data[WGRC_BIT_AUTO]))
		else $error("guiding mode wrong");

	a_manual_jog: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && !cmd_data[WGRC_BIT_AUTO])
		|=> ctrl.jog_left == $past(cmd_data[WGRC_BIT_LEFT]) && ctrl.jog_right == $past(cmd_data[WGRC_BIT_RIGHT]))
		else $error("manual jog level wrong");

	a_left_stop: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && !cmd_data[WGRC_BIT_LEFT])
		|=> !ctrl.jog_left)
		else $error("left jog not stopped");

	a_right_stop: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && !cmd_data[WGRC_BIT_RIGHT])
		|=> !ctrl.jog_right)
		else $error("right jog not stopped");

	a_auto_no_jog: assert property (@(posedge clk) disable iff (rst)
		ctrl.auto_mode
		|-> !ctrl.jog_left && !ctrl.jog_right)
		else $error("jog running in automatic mode");

	a_reserved_ign: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && cmd_data[15:8] == cmd_ff[15:8])
		|=> $stable(ctrl) && $stable(guide_point))
		else $error("reserved bits changed behaviour");

	// guide point stepping; a held bit must never step twice
	a_step_up_once: assert property (@(posedge clk) disable iff (rst)
		(step_up && !step_dn && $signed(gp_ff) <= $signed(GP_MAX) - $signed(WGRC_GP_STEP))
		|=> guide_point == $past(gp_ff) + $signed(WGRC_GP_STEP))
		else $error("guide point did not rise one step");

	a_step_dn_once: assert property (@(posedge clk) disable iff (rst)
		(step_dn && !step_up && $signed(gp_ff) >= $signed(GP_MIN) + $signed(WGRC_GP_STEP))
		|=> guide_point == $past(gp_ff) - $signed(WGRC_GP_STEP))
		else $error("guide point did not fall one step");

	a_up_never_falls: assert property (@(posedge clk) disable iff (rst)
		(step_up && !step_dn)
		|=> guide_point >= $past(gp_ff))
		else $error("guide point fell on a raise");

	a_dn_never_rises: assert property (@(posedge clk) disable iff (rst)
		(step_dn && !step_up)
		|=> guide_point <= $past(gp_ff))
		else $error("guide point rose on a lower");

	a_held_no_step: assert property (@(posedge clk) disable iff (rst)
		(!step_up && !step_dn)
		|=> $stable(guide_point))
		else $error("guide point moved without a rising step");

	a_idle_gp: assert property (@(posedge clk) disable iff (rst)
		!cmd_wr
		|=> $stable(guide_point))
		else $error("guide point moved without a write");

	a_manual_no_step: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && !cmd_data[WGRC_BIT_AUTO])
		|=> $stable(guide_point))
		else $error("guide point stepped in manual mode");

	a_held_up_no_step: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && cmd_ff[WGRC_BIT_RIGHT] && !(cmd_data[WGRC_BIT_AUTO] && cmd_data[WGRC_BIT_LEFT] && !cmd_ff[WGRC_BIT_LEFT]))
		|=> $stable(guide_point))
		else $error("held raise bit stepped again");

	a_held_dn_no_step: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && cmd_ff[WGRC_BIT_LEFT] && !(cmd_data[WGRC_BIT_AUTO] && cmd_data[WGRC_BIT_RIGHT] && !cmd_ff[WGRC_BIT_RIGHT]))
		|=> $stable(guide_point))
		else $error("held lower bit stepped again");

	// opposite steps in one write cancel rather than pick a winner
	a_both_no_step: assert property (@(posedge clk) disable iff (rst)
		(step_up && step_dn)
		|=> $stable(guide_point))
		else $error("guide point moved on opposing steps");

	a_gp_limits: assert property (@(posedge clk) disable iff (rst)
		$signed(guide_point) <= $signed(GP_MAX) && $signed(guide_point) >= $signed(GP_MIN))
		else $error("guide point past its limit");

	a_up_sat: assert property (@(posedge clk) disable iff (rst)
		(step_up && !step_dn && $signed(gp_ff) > $signed(GP_MAX) - $signed(WGRC_GP_STEP))
		|=> guide_point == $signed(GP_MAX))
		else $error("raise not truncated to the limit");

	a_dn_sat: assert property (@(posedge clk) disable iff (rst)
		(step_dn && !step_up && $signed(gp_ff) < $signed(GP_MIN) + $signed(WGRC_GP_STEP))
		|=> guide_point == $signed(GP_MIN))
		else $error("lower not truncated to the limit");

	// brightness overrides per sensor
	a_light_gate: assert property (@(posedge clk) disable iff (rst)
		!brt_cmd_ff[WGRC_BIT_LIGHT]
		|=> !s1_brt.load && !s1_brt.seed && !s2_brt.load && !s2_brt.seed)
		else $error("brightness applied without light enable");

	a_brt_cmd_hold: assert property (@(posedge clk) disable iff (rst)
		!brt_cmd_wr
		|=> $stable(brt_cmd_ff))
		else $error("brightness word changed without a write");

	a_s1_load: assert property (@(posedge clk) disable iff (rst)
		(s1_val_wr && brt_cmd_ff[WGRC_BIT_LIGHT] && brt_cmd_ff[WGRC_BIT_S1_OVR] && !auto_brt_s1)
		|=> s1_brt.load && !s1_brt.seed && s1_brt.value == $past(s1_val_data))
		else $error("sensor one override not applied");

	a_s2_load: assert property (@(posedge clk) disable iff (rst)
		(s2_val_wr && brt_cmd_ff[WGRC_BIT_LIGHT] && brt_cmd_ff[WGRC_BIT_S2_OVR] && !auto_brt_s2)
		|=> s2_brt.load && !s2_brt.seed && s2_brt.value == $past(s2_val_data))
		else $error("sensor two override not applied");

	a_s1_seed: assert property (@(posedge clk) disable iff (rst)
		(s1_val_wr && brt_cmd_ff[WGRC_BIT_LIGHT] && brt_cmd_ff[WGRC_BIT_S1_OVR] && auto_brt_s1)
		|=> s1_brt.seed && !s1_brt.load && s1_brt.value == $past(s1_val_data))
		else $error("sensor one seed not applied");

	a_s2_seed: assert property (@(posedge clk) disable iff (rst)
		(s2_val_wr && brt_cmd_ff[WGRC_BIT_LIGHT] && brt_cmd_ff[WGRC_BIT_S2_OVR] && auto_brt_s2)
		|=> s2_brt.seed && !s2_brt.load && s2_brt.value == $past(s2_val_data))
		else $error("sensor two seed not applied");

	a_s1_ovr_off: assert property (@(posedge clk) disable iff (rst)
		(s1_val_wr && !brt_cmd_ff[WGRC_BIT_S1_OVR])
		|=> !s1_brt.load && !s1_brt.seed)
		else $error("sensor one taken without its enable");

	a_s2_ovr_off: assert property (@(posedge clk) disable iff (rst)
		(s2_val_wr && !brt_cmd_ff[WGRC_BIT_S2_OVR])
		|=> !s2_brt.load && !s2_brt.seed)
		else $error("sensor two taken without its enable");

	a_s1_val_hold: assert property (@(posedge clk) disable iff (rst)
		!s1_val_wr
		|=> $stable(s1_brt.value) && !s1_brt.load && !s1_brt.seed)
		else $error("sensor one value moved without a write");

	a_s2_val_hold: assert property (@(posedge clk) disable iff (rst)
		!s2_val_wr
		|=> $stable(s2_brt.value) && !s2_brt.load && !s2_brt.seed)
		else $error("sensor two value moved without a write");

	a_s1_pulse_excl: assert property (@(posedge clk) disable iff (rst)
		!(s1_brt.load && s1_brt.seed))
		else $error("sensor one load and seed together");

	a_s2_pulse_excl: assert property (@(posedge clk) disable iff (rst)
		!(s2_brt.load && s2_brt.seed))
		else $error("sensor two load and seed together");
endmodule

// File: bench/wgrc_plc_model.sv
`timescale 1ns/1ps
module wgrc_plc_model (
	input wire logic clk,
	output logic cmd_wr,
	output logic [15:0] cmd_data,
	output logic brt_cmd_wr,
	output logic [15:0] brt_cmd_data,
	output logic s1_val_wr,
	output logic [5:0] s1_val_data,
	output logic s2_val_wr,
	output logic [5:0] s2_val_data
);
	initial begin
		{cmd_wr, brt_cmd_wr, s1_val_wr, s2_val_wr} = 4'h0;
		{cmd_data, brt_cmd_data} = 32'h0000_0000;
		{s1_val_data, s2_val_data} = 12'h000;
	end
	// one strobe per call; data inverted after so stale words never look valid
	task automatic put(input int sel, input logic [15:0] d);
		@(posedge clk);
		#1;
		case (sel)
			0: {cmd_wr, cmd_data} = {1'b1, d[15:8], 8'h00};
			1: {brt_cmd_wr, brt_cmd_data} = {1'b1, d};
			2: {s1_val_wr, s1_val_data} = {1'b1, d[5:0]};
			default: {s2_val_wr, s2_val_data} = {1'b1, d[5:0]};
		endcase
		@(posedge clk);
		#1;
		{cmd_wr, brt_cmd_wr, s1_val_wr, s2_val_wr} = 4'h0;
		{cmd_data, brt_cmd_data} = ~{cmd_data, brt_cmd_data};
		{s1_val_data, s2_val_data} = ~{s1_val_data, s2_val_data};
	endtask
endmodule

// File: bench/wgrc_top_tb.sv
`timescale 1ns/1ps
module wgrc_top_tb
	import wgrc_pkg::*;
;
	logic clk, rst, auto_brt_s1, auto_brt_s2, cmd_wr, brt_cmd_wr, s1_val_wr, s2_val_wr, local_enable;
	logic [15:0] cmd_data, brt_cmd_data;
	logic [5:0] s1_val_data, s2_val_data;
	logic signed [15:0] guide_point;
	wgrc_ctrl_t ctrl;
	wgrc_brt_t s1_brt, s2_brt;
	int num_errors = 0;
	int n_checks = 0;
	wgrc_plc_model plc_u (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .brt_cmd_wr(brt_cmd_wr),
		.brt_cmd_data(brt_cmd_data), .s1_val_wr(s1_val_wr), .s1_val_data(s1_val_data),
		.s2_val_wr(s2_val_wr), .s2_val_data(s2_val_data));
	// narrow limits so saturation is reached in a few steps
	wgrc_top #(.GP_MIN(16'hfff8), .GP_MAX(16'h0008)) dut_u (.clk(clk), .rst(rst), .cmd_wr(cmd_wr),
		.cmd_data(cmd_data), .brt_cmd_wr(brt_cmd_wr), .brt_cmd_data(brt_cmd_data),
		.auto_brt_s1(auto_brt_s1), .auto_brt_s2(auto_brt_s2), .s1_val_wr(s1_val_wr),
		.s1_val_data(s1_val_data), .s2_val_wr(s2_val_wr), .s2_val_data(s2_val_data), .ctrl(ctrl),
		.local_enable(local_enable), .guide_point(guide_point), .s1_brt(s1_brt), .s2_brt(s2_brt));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic t_mode();
		chk("ctrl", 16'h0000, {12'h000, ctrl});
		chk("local", 16'h0001, {15'h0000, local_enable});
		plc_u.put(0, 16'h0100);
		chk("local", 16'h0000, {15'h0000, local_enable});
		plc_u.put(0, 16'h0500);
		chk("ctrl", 16'h000a, {12'h000, ctrl});
		plc_u.put(0, 16'h0900);
		chk("ctrl", 16'h0009, {12'h000, ctrl});
		plc_u.put(0, 16'h0b00);
		chk("ctrl", 16'h000c, {12'h000, ctrl});
		chk("gp", 16'h0000, guide_point);
		plc_u.put(0, 16'h0000);
		chk("local", 16'h0001, {15'h0000, local_enable});
	endtask
	task automatic t_steps();
		int e;
		for (int i = 1; i <= 3; i++) begin
			plc_u.put(0, 16'h0200);
			plc_u.put(0, 16'h0a00);
			e = (4 * i > 8) ? 8 : 4 * i;
			chk("gp up", 16'(e), guide_point);
		end
		for (int i = 1; i <= 5; i++) begin
			plc_u.put(0, 16'h0200);
			plc_u.put(0, 16'h0600);
			plc_u.put(0, 16'h0600);
			e = (8 - 4 * i < -8) ? -8 : 8 - 4 * i;
			chk("gp down", 16'(e), guide_point);
		end
	endtask
	task automatic t_brt();
		plc_u.put(1, 16'h4040);
		plc_u.put(2, 16'h0005);
		chk("s1", 16'h0000, {8'h00, s1_brt});
		plc_u.put(1, 16'h8040);
		plc_u.put(2, 16'h0005);
		chk("s1", 16'h0000, {8'h00, s1_brt});
		plc_u.put(1, 16'hc040);
		plc_u.put(2, 16'h0005);
		chk("s1", 16'h0085, {8'h00, s1_brt});
		plc_u.put(3, 16'h0007);
		chk("s2", 16'h0047, {8'h00, s2_brt});
		@(posedge clk);
		#1;
		chk("s2 pulse", 16'h0007, {8'h00, s2_brt});
	endtask
	initial begin
		rst = 1'b1;
		auto_brt_s1 = 1'b0;
		auto_brt_s2 = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		t_mode();
		t_steps();
		t_brt();
		give_verdict();
	end
	initial begin
		#20000;
		num_errors++;
		give_verdict();
	end
endmodule
